// ### core/attach_cfg.svh
// Purpose: field positions, reset value, write mask and timing counts
// Assumes: 125 MHz raw clock
// Notes:   definitions only
`ifndef ATTACH_CFG_SVH
`define ATTACH_CFG_SVH

`define APC_RESET            32'h0004_0000
`define APC_PORT_EN          31
`define APC_SRC_HI           30
`define APC_SRC_LO           29
`define APC_STAT_HI          25
`define APC_STAT_LO          24
`define APC_DET_EN           23
`define APC_ACT_LEN          22
`define APC_WARM_LEN         21
`define APC_INTERVAL         20
`define APC_CMP_HI           19
`define APC_CMP_LO           18
`define APC_REF_LVL          17
`define APC_FORCE            16
`define APC_VS_POL           4
`define APC_WR_MASK          32'hE0FF_0010

`define CLK_MHZ              125
`define ACT_SHORT_CYC        64
`define ACT_LONG_CYC         128
`define WARM_SHORT_MS        4
`define WARM_LONG_MS         8
`define INTERVAL_SHORT_S     2
`define INTERVAL_LONG_S      4
`define WARM_SHORT_CYC       (`WARM_SHORT_MS * `CLK_MHZ * 1000)
`define WARM_LONG_CYC        (`WARM_LONG_MS * `CLK_MHZ * 1000)
`define INTERVAL_SHORT_CYC   (`INTERVAL_SHORT_S * `CLK_MHZ * 1000000)
`define INTERVAL_LONG_CYC    (`INTERVAL_LONG_S * `CLK_MHZ * 1000000)

`endif

// ### core/attach_pkg.sv
// Purpose: types shared by the attach detection block
// Assumes: nothing
// Notes:   constants live in attach_cfg.svh
package attach_pkg;
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_WARM   = 2'b01,
    ST_ACTIVE = 2'b10,
    ST_UPDATE = 2'b11
  } detect_state_t;

  typedef enum logic [1:0] {
    SRC_FIRST  = 2'b00,
    SRC_SECOND = 2'b01,
    SRC_THIRD  = 2'b10,
    SRC_NONE   = 2'b11
  } source_sel_t;
endpackage

// ### core/detect_engine.sv
// Purpose: one detection cycle: warm-up, activation compare, single result
// Assumes: sense inputs synchronous to clk
// Notes:   compare latched at end of activation
`timescale 1ns/1ps
`default_nettype none
`include "attach_cfg.svh"
module detect_engine
  import attach_pkg::*;
#(
  parameter int unsigned WARM_SHORT = `WARM_SHORT_CYC,
  parameter int unsigned WARM_LONG  = `WARM_LONG_CYC
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // control
  input  wire logic       start,
  input  wire logic       act_long,
  input  wire logic       warm_long,
  // sensed compare results per channel: bit0 blue, bit1 green
  input  wire logic [1:0] sense_above,
  // result
  output logic            busy,
  output logic            done,
  output logic      [1:0] result
);
  detect_state_t state;
  detect_state_t next_state;
  logic [31:0]   count;
  logic [31:0]   warm_cyc;
  logic [31:0]   act_cyc;
  logic [1:0]    seen;
  wire           count_end = (count == 32'h0000_0000);

  assign warm_cyc = warm_long ? WARM_LONG : WARM_SHORT;
  assign act_cyc  = act_long ? 32'(`ACT_LONG_CYC) : 32'(`ACT_SHORT_CYC);
  assign busy     = (state != ST_IDLE);
  assign done     = (state == ST_UPDATE);

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_comb begin
    case (state)
      ST_IDLE:   next_state = start ? ST_WARM : ST_IDLE;
      ST_WARM:   next_state = count_end ? ST_ACTIVE : ST_WARM;
      ST_ACTIVE: next_state = count_end ? ST_UPDATE : ST_ACTIVE;
      ST_UPDATE: next_state = ST_IDLE;
      default:   next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state  <= ST_IDLE;
      count  <= 32'h0000_0000;
      seen   <= 2'h0;
      result <= 2'h0;
    end else begin
      state <= next_state;
      if (state == ST_IDLE && start) begin
        count <= warm_cyc - 32'd1;
      end else if (state == ST_WARM && count_end) begin
        count <= act_cyc - 32'd1;
        seen  <= 2'h0;
      end else if (!count_end) begin
        count <= count - 32'd1;
      end
      // any sample above threshold in the window counts as attached
      if (state == ST_ACTIVE) begin
        seen <= seen | sense_above;
      end
      if (state == ST_ACTIVE && count_end) begin
        result <= seen | sense_above;
      end
    end
  end

  AST_ACT_LEN: assert property (@(posedge clk) disable iff (reset)
    $rose(state == ST_ACTIVE) && !act_long |-> (state == ST_ACTIVE)[*8])
    else $error("activation ended too early");
  AST_ONE_DONE: assert property (@(posedge clk) disable iff (reset)
    done |=> !done)
    else $error("update lasted more than one cycle");
endmodule
`default_nettype wire

// ### core/analog_port_attach_detect.sv
// Purpose: analog port control register and attach/detach detection
// Assumes: register written through plain write strobe with byte-free data
// Notes:   long intervals are parameters for simulation
// Overview of operation
// - port enable drives converter and syncs
// - channel status reports attached colour channels
// - writing one clears a status bit
// - status edges ORed into interrupt status
// - automatic detection only while enable set
// - activation lasts 64 or 128 clocks
// - warm-up about 4 or 8 ms
// - idle sample interval 2 or 4 seconds
// - reference 325/475 mV, pair with code 11b
// - force start runs one cycle, self-clears
// - vsync polarity and its idle level
`timescale 1ns/1ps
`default_nettype none
`include "attach_cfg.svh"
module analog_port_attach_detect
  import attach_pkg::*;
#(
  parameter int unsigned WARM_SHORT     = `WARM_SHORT_CYC,
  parameter int unsigned WARM_LONG      = `WARM_LONG_CYC,
  parameter int unsigned INTERVAL_SHORT = `INTERVAL_SHORT_CYC,
  parameter int unsigned INTERVAL_LONG  = `INTERVAL_LONG_CYC
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // register port
  input  wire logic        reg_write,
  input  wire logic [31:0] reg_wdata,
  output logic      [31:0] reg_rdata,
  // transcoder state and raw sync
  input  wire logic        transcoder_enabled,
  input  wire logic        vsync_raw,
  input  wire logic        hsync_raw,
  // analog sense from the monitor side
  input  wire logic [1:0]  sense_above,
  // analog front end controls
  output logic             converter_enable,
  output logic       [1:0] source_select,
  output logic       [6:0] detect_threshold,
  output logic             detect_reference_level,
  output logic             detect_circuit_on,
  // syncs toward the monitor
  output logic             vsync_out,
  output logic             hsync_out,
  // event toward display interrupt status
  output logic             display_interrupt_status
);
  // ----------------------------------------
  // control register
  // ----------------------------------------
  logic [31:0] analog_port_control;
  logic [1:0]  attach_channel_status;
  logic [1:0]  recorded;
  logic [1:0]  status_prev;
  logic [31:0] interval_count;
  logic        eng_busy;
  logic        eng_done;
  logic [1:0]  eng_result;
  logic        forced_run;

  wire port_enable            = analog_port_control[`APC_PORT_EN];
  wire attach_detect_enable   = analog_port_control[`APC_DET_EN];
  wire detect_activation_length = analog_port_control[`APC_ACT_LEN];
  wire detect_warmup_length   = analog_port_control[`APC_WARM_LEN];
  wire detect_sample_interval = analog_port_control[`APC_INTERVAL];
  wire [1:0] detect_compare_code =
    analog_port_control[`APC_CMP_HI:`APC_CMP_LO];
  wire detect_force_start     = analog_port_control[`APC_FORCE];
  wire vsync_active_high      = analog_port_control[`APC_VS_POL];

  // writes of ones clear status; hardware set wins over that clear
  wire [1:0] status_clear = reg_write ? reg_wdata[`APC_STAT_HI:`APC_STAT_LO] : 2'h0;
  wire [1:0] change       = eng_result ^ recorded;
  wire       take_result  = eng_done && (forced_run || attach_detect_enable);
  wire [1:0] status_set   = take_result ? (eng_result & change) : 2'h0;

  // sampling: continuous while transcoder runs, spaced out while it is off
  wire [31:0] interval_cyc = detect_sample_interval ? INTERVAL_LONG : INTERVAL_SHORT;
  wire interval_end  = (interval_count == 32'h0000_0000);
  wire auto_start    = attach_detect_enable && !eng_busy &&
                       (transcoder_enabled || interval_end);
  wire force_start   = detect_force_start && !eng_busy;
  wire engine_start  = auto_start || force_start;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      analog_port_control <= `APC_RESET;
    end else begin
      // trigger bit drops when its cycle finishes
      if (eng_done && forced_run) begin
        analog_port_control[`APC_FORCE] <= 1'b0;
      end
      // a write in the same cycle overrides the self-clear: a trigger written in that cycle is kept
      if (reg_write) begin
        analog_port_control <= reg_wdata & `APC_WR_MASK;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      attach_channel_status <= 2'h0;
      recorded              <= 2'h0;
      status_prev           <= 2'h0;
      forced_run            <= 1'b0;
      interval_count        <= 32'h0000_0000;
    end else begin
      attach_channel_status <= (attach_channel_status & ~status_clear)
                               | status_set;
      status_prev <= attach_channel_status;
      if (take_result) begin
        recorded <= eng_result;
      end
      if (engine_start) begin
        forced_run <= force_start;
      end else if (eng_done) begin
        forced_run <= 1'b0;
      end
      if (engine_start) begin
        interval_count <= interval_cyc - 32'd1;
      end else if (!interval_end && !eng_busy) begin
        interval_count <= interval_count - 32'd1;
      end
    end
  end

  // ----------------------------------------
  // detection engine
  // ----------------------------------------
  detect_engine #(
    .WARM_SHORT (WARM_SHORT),
    .WARM_LONG  (WARM_LONG)
  ) detect_engine_i (
    .clk         (clk),
    .reset       (reset),
    .start       (engine_start),
    .act_long    (detect_activation_length),
    .warm_long   (detect_warmup_length),
    .sense_above (sense_above),
    .busy        (eng_busy),
    .done        (eng_done),
    .result      (eng_result)
  );

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // any edge of either status bit raises the event
  wire [1:0] status_edge = attach_channel_status ^ status_prev;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      display_interrupt_status <= 1'b0;
      vsync_out                <= 1'b0;
      hsync_out                <= 1'b0;
    end else begin
      display_interrupt_status <= |status_edge;
      // idle level is the inverse of the polarity bit, i.e. inactive state
      vsync_out <= port_enable ? (vsync_raw ~^ vsync_active_high)
                               : ~vsync_active_high;
      hsync_out <= port_enable ? hsync_raw : 1'b0;
    end
  end

  assign converter_enable       = port_enable;
  assign source_select          = analog_port_control[`APC_SRC_HI:`APC_SRC_LO];
  // threshold 40/50/60/70 from the two-bit code
  assign detect_threshold       = 7'd40 + {detect_compare_code, 3'b000}
                                  + {3'b000, detect_compare_code, 1'b0};
  assign detect_reference_level = analog_port_control[`APC_REF_LVL];
  assign detect_circuit_on      = eng_busy;
  assign reg_rdata = {analog_port_control[31:26], attach_channel_status,
                      analog_port_control[23:0]};

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  sequence det_start_s;
    engine_start && !eng_busy;
  endsequence
  sequence det_warm_s;
    eng_busy && !eng_done;
  endsequence

  AST_FORCE_CLEARS: assert property (@(posedge clk) disable iff (reset)
    eng_done && forced_run && !reg_write |=> !detect_force_start)
    else $error("force bit not cleared after cycle");
  AST_NO_AUTO_OFF: assert property (@(posedge clk) disable iff (reset)
    !attach_detect_enable && !detect_force_start |-> !engine_start)
    else $error("detection started while disabled");
  AST_IRQ_EDGE: assert property (@(posedge clk) disable iff (reset)
    $changed(attach_channel_status) |=> display_interrupt_status)
    else $error("status edge missed interrupt");
  AST_CLEAR: assert property (@(posedge clk) disable iff (reset)
    reg_write && reg_wdata[`APC_STAT_LO] && !status_set[0]
    |=> !attach_channel_status[0])
    else $error("status bit not cleared");
  AST_VS_IDLE: assert property (@(posedge clk) disable iff (reset)
    !port_enable |=> vsync_out == !$past(vsync_active_high))
    else $error("vsync idle level wrong");
  AST_EN: assert property (@(posedge clk) disable iff (reset)
    converter_enable == analog_port_control[31])
    else $error("converter enable mismatch");
  AST_ONCHANGE: assert property (@(posedge clk) disable iff (reset)
    !take_result && !$past(take_result) |-> status_set == 2'h0)
    else $error("status set without detection");
  AST_THRESH: assert property (@(posedge clk) disable iff (reset)
    detect_compare_code == 2'b11 |-> detect_threshold == 7'd70)
    else $error("threshold code 11 not 70");
  AST_HS_IDLE: assert property (@(posedge clk) disable iff (reset)
    !port_enable |=> !hsync_out)
    else $error("hsync not idle while port off");
  AST_VS_ACTIVE: assert property (@(posedge clk) disable iff (reset)
    port_enable |=> vsync_out == ($past(vsync_raw) ~^ $past(vsync_active_high)))
    else $error("vsync polarity wrong");
  AST_SET_AT_DONE: assert property (@(posedge clk) disable iff (reset)
    |(attach_channel_status & ~$past(attach_channel_status)) |-> $past(eng_done))
    else $error("status set outside a cycle end");
  AST_NO_SET_SAME: assert property (@(posedge clk) disable iff (reset)
    take_result && eng_result == recorded && !reg_write |=> $stable(attach_channel_status))
    else $error("status changed without new attachment");
  AST_START_SEQ: assert property (@(posedge clk) disable iff (reset)
    det_start_s |=> det_warm_s)
    else $error("cycle did not begin with warm-up");
endmodule
`default_nettype wire

// ### testbench/monitor_model.sv
// Purpose: analog monitor load seen by the attach detect sense comparators
// Assumes: sense is only meaningful while the detect circuit is powered
// Notes:   outside detection the lines wander so stale values are never trusted
`timescale 1ns/1ps
`default_nettype none
module monitor_model (
  // clock
  input  wire logic       clk,
  // detect circuit power and attached load
  input  wire logic       circuit_on,
  input  wire logic [1:0] attached,
  // per-channel compare result
  output var  logic [1:0] sense_above
);
  // ----------------------------------------
  // sense lines
  // ----------------------------------------
  logic [1:0] wander = 2'b01;
  always @(posedge clk) begin
    wander <= ~wander;
    if (circuit_on) begin
      sense_above <= attached;
    end else begin
      sense_above <= wander;
    end
  end
endmodule
`default_nettype wire

// ### testbench/analog_port_attach_detect_tb.sv
// Purpose: self-checking bench for the analog port attach detect block
// Assumes: short warm-up and interval parameters
// Notes:   status seen at each interrupt pulse is matched against a queue
`timescale 1ns/1ps
`default_nettype none
module analog_port_attach_detect_tb;
  localparam int WS = 20, WL = 40, IS = 100, IL = 200;
  logic        clk, reset, reg_write, tr_en, vsync_raw, hsync_raw;
  logic [31:0] reg_wdata, reg_rdata, rnd;
  logic [1:0]  sense_above, attached, src;
  logic        conv_en, ref_lvl, circ_on, vsync_out, hsync_out, irq;
  logic [6:0]  thr;
  int          fail_count, n_checks, n, gap, want;
  logic [1:0]  expq[$];
  // ----------------------------------------
  // design and monitor
  // ----------------------------------------
  analog_port_attach_detect #(.WARM_SHORT(WS), .WARM_LONG(WL), .INTERVAL_SHORT(IS),
    .INTERVAL_LONG(IL)) analog_port_attach_detect_i (.clk(clk), .reset(reset),
    .reg_write(reg_write), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .transcoder_enabled(tr_en), .vsync_raw(vsync_raw), .hsync_raw(hsync_raw),
    .sense_above(sense_above), .converter_enable(conv_en), .source_select(src),
    .detect_threshold(thr), .detect_reference_level(ref_lvl),
    .detect_circuit_on(circ_on), .vsync_out(vsync_out), .hsync_out(hsync_out),
    .display_interrupt_status(irq));
  monitor_model monitor_model_i (.clk(clk), .circuit_on(circ_on), .attached(attached),
    .sense_above(sense_above));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [31:0] d);
    @(posedge clk);
    reg_write <= 1'b1;
    reg_wdata <= d;
    @(posedge clk);
    reg_write <= 1'b0;
    #1;
  endtask
  // waits for one detection cycle; gap is the idle time before it started
  task automatic wait_cycle(input int lo, input int limit);
    gap = 0;
    while (circ_on !== 1'b1 && gap < limit) begin @(posedge clk); #1; gap++; end
    n = 0;
    while (circ_on === 1'b1 && n < 2000) begin @(posedge clk); #1; n++; end
    chk("on_len", 32'(n >= lo && n <= lo + 2), 1);
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // clock, watchdog, interrupt watcher
  // ----------------------------------------
  initial begin clk = 1'b0; forever #4 clk = ~clk; end
  initial begin #(8 * 20000); fail_count++; print_verdict; end
  always @(negedge clk) begin
    if (irq === 1'b1) begin
      if (expq.size() == 0) chk("irq_extra", 1, 0);
      else chk("irq_status", 32'(reg_rdata[25:24]), 32'(expq.pop_front()));
    end
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    reset = 1'b1; reg_write = 1'b0; reg_wdata = '0; tr_en = 1'b0; vsync_raw = 1'b0;
    hsync_raw = 1'b0; attached = 2'b00; rnd = 32'd13008; fail_count = 0; n_checks = 0;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk); #1;
    chk("rdata", reg_rdata, 32'h0004_0000);
    chk("thr", 32'(thr), 32'd50);
    chk("conv", 32'(conv_en), 0);
    $display("test reset done");
    for (int s = 0; s < 6; s++) begin
      wr({1'b1, 2'(s % 3), 24'h0, 1'(s / 3), 4'h0});
      chk("conv", 32'(conv_en), 1);
      chk("src", 32'(src), 32'(s % 3));
      repeat (4) begin
        rnd = xs(rnd);
        @(posedge clk);
        vsync_raw <= rnd[0];
        hsync_raw <= rnd[1];
        @(posedge clk); #1;
        chk("vsync", 32'(vsync_out), 32'(rnd[0] == 1'(s / 3)));
        chk("hsync", 32'(hsync_out), 32'(rnd[1]));
      end
    end
    for (int p = 0; p < 2; p++) begin
      wr({27'h0, 1'(p), 4'h0});
      repeat (2) @(posedge clk);
      #1;
      chk("vsync_idle", 32'(vsync_out), 32'(p == 0));
      chk("hsync_idle", 32'(hsync_out), 0);
      chk("conv", 32'(conv_en), 0);
    end
    $display("test port done");
    for (int c = 0; c < 4; c++) begin
      wr({12'h0, 2'(c), 1'(c == 3), 17'h0});
      chk("thr", 32'(thr), 32'(40 + 10 * c));
      chk("ref", 32'(ref_lvl), 32'(c == 3));
    end
    $display("test compare done");
    attached <= 2'b01;
    expq.push_back(2'b01);
    wr(32'h0001_0000);
    wait_cycle(WS + 64, 50);
    chk("status", 32'(reg_rdata[25:24]), 1);
    chk("force", 32'(reg_rdata[16]), 0);
    wr(32'h0000_0000);
    chk("status", 32'(reg_rdata[25:24]), 1);
    expq.push_back(2'b00);
    wr(32'h0100_0000);
    chk("status", 32'(reg_rdata[25:24]), 0);
    wr(32'h0001_0000);
    wait_cycle(WS + 64, 50);
    chk("status", 32'(reg_rdata[25:24]), 0);
    attached <= 2'b10;
    expq.push_back(2'b10);
    wr(32'h0061_0000);
    wait_cycle(WL + 128, 60);
    chk("status", 32'(reg_rdata[25:24]), 2);
    expq.push_back(2'b00);
    wr(32'h0200_0000);
    $display("test forced done");
    attached <= 2'b00;
    n = 0;
    repeat (300) begin @(posedge clk); #1; if (circ_on === 1'b1) n++; end
    chk("idle_on", 32'(n), 0);
    attached <= 2'b01;
    expq.push_back(2'b01);
    for (int iv = 0; iv < 2; iv++) begin
      want = iv ? IL : IS;
      wr(32'h0080_0000 | (32'(iv) << 20));
      wait_cycle(WS + 64, IL + 10);
      wait_cycle(WS + 64, IL + 10);
      chk("interval", 32'(gap + 3 >= want - 2 && gap + 3 <= want + 3), 1);
    end
    @(posedge clk);
    tr_en <= 1'b1;
    wait_cycle(WS + 64, 10);
    chk("continuous", 32'(circ_on), 1);
    wr(32'h0000_0000);
    repeat (5) @(posedge clk);
    chk("irq_left", 32'(expq.size()), 0);
    $display("test auto done");
    print_verdict;
  end
endmodule
`default_nettype wire
